// ### common/asq_pkg.sv
package asq_pkg;

    // ****************************************************************
    // Register map (byte addresses on the AXI4-Lite bus)
    // ****************************************************************
    localparam logic [7:0] ASQ_OFS_MODE = 8'h00;
    localparam logic [7:0] ASQ_OFS_RESULT = 8'h04;
    localparam logic [7:0] ASQ_OFS_TRIG = 8'h08;
    localparam logic [7:0] ASQ_OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ASQ_OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] ASQ_OFS_STATE = 8'h14;

    // ****************************************************************
    // Mode register field positions
    // ****************************************************************
    localparam int ASQ_MODE_START_BIT = 0;
    localparam int ASQ_MODE_HWSTART_BIT = 1;
    localparam int ASQ_MODE_SCAN_BIT = 2;
    localparam int ASQ_MODE_HOLD_BIT = 3;
    localparam int ASQ_MODE_CH_LSB = 4;
    localparam int ASQ_CH_W = 4;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int ASQ_CHANNELS = 12;
    localparam int ASQ_RES_W = 8;
    localparam logic [3:0] ASQ_LAST_CH = 4'hB;
    localparam logic [7:0] ASQ_MODE_RESET = 8'h00;
    localparam logic [1:0] ASQ_TRIG_RESET = 2'h0;
    localparam logic [7:0] ASQ_RESULT_RESET = 8'h00;

    // ****************************************************************
    // Conversion timing
    // ****************************************************************
    localparam int ASQ_CLK_HZ = 20000000;
    localparam int ASQ_CONV_NS = 10000;
    localparam int ASQ_CONV_CYC = (ASQ_CONV_NS * (ASQ_CLK_HZ / 1000000)) / 1000;
    // The frame holds a sample phase and eight equal bit steps.
    localparam int ASQ_STEP_CYC = ASQ_CONV_CYC / (ASQ_RES_W + 1);
    localparam int ASQ_SAMPLE_CYC = ASQ_CONV_CYC - (ASQ_RES_W * ASQ_STEP_CYC);
    localparam int ASQ_CNT_W = 8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ASQ_TRG_HEAD_ONE,
        ASQ_TRG_HEAD_TWO,
        ASQ_TRG_FRAME_THREE,
        ASQ_TRG_INTERVAL
    } asq_trig_sel_t;

    typedef enum logic [1:0] {
        ASQ_IDLE,
        ASQ_SAMPLE,
        ASQ_CONVERT,
        ASQ_HOLDOFF
    } asq_state_t;

    typedef struct packed {
        logic [3:0] channel;
        logic holdOff;
        logic scan;
        logic hwStart;
        logic start;
    } asq_mode_t;

    // Timer coincidence pulses from the timer units outside the block.
    typedef struct packed {
        logic intervalTimerCompare;
        logic frameTimerCompareThree;
        logic headTimerCompareTwo;
        logic headTimerCompareOne;
    } asq_trig_t;

endpackage : asq_pkg

// ### core/asq_adc_sequencer.sv
// Summary of operation
// - Mux selects one of twelve inputs
// - Eight-bit result held until next overwrite
// - Successive approximation, 10 us per channel
// - Hardware trigger starts conversion without software
// - Software start bit begins conversion
// - Scan mode converts inputs in sequence
// - Select mode repeats one chosen input
// - Result transfer raises completion interrupt
// - Hold-off waits until result is read
// - Trigger chosen from four timer coincidences
// - Maskable completion interrupt with control register
module asq_adc_sequencer (
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer trigger pulses, same clock domain.
    input wire asq_pkg::asq_trig_t timerTrig,
    // Analog side: channel select, sample strobe, DAC code, comparator.
    output logic [3:0] muxChannel,
    output logic sampleHold,
    output logic [7:0] dacCode,
    input wire logic compHigh,
    output logic conversionDoneIrq
);
    import asq_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    // All state lives in one struct so the next-value copy and the register stay in step.
    typedef struct packed {
        logic awReady;
        logic wReady;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic haveAw;
        logic haveW;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        asq_mode_t mode;
        asq_trig_sel_t trigSel;
        logic [7:0] result;
        logic resultUnread;
        logic irqStatus;
        logic irqMask;
        asq_state_t state;
        logic [3:0] channel;
        logic [7:0] sar;
        logic [2:0] bitIdx;
        logic [ASQ_CNT_W-1:0] cnt;
        logic compSync1;
        logic compSync2;
        logic irqOut;
        logic sampleOut;
        logic [7:0] dacOut;
    } asq_core_t;

    asq_core_t q;
    asq_core_t next_q;

    // Sample phase and per-bit timing inside the 10 us frame.
    // With eight bit steps the sample phase takes what the frame has left.
    localparam logic [ASQ_CNT_W-1:0] SAMPLE_CNT = ASQ_CNT_W'(ASQ_SAMPLE_CYC - 1);
    localparam logic [ASQ_CNT_W-1:0] STEP_CNT = ASQ_CNT_W'(ASQ_STEP_CYC - 1);

    logic trigHit;
    logic wrFire;
    logic rdFire;
    logic resultRead;
    logic startReq;
    logic [31:0] rdMux;
    logic [7:0] trial;
    logic modeWr;
    logic [3:0] selCh;

    // ****************************************************************
    // Trigger selection
    // ****************************************************************
    // Triggers are one-cycle pulses from timer units on this clock.
    // Only the selected coincidence may start a conversion.
    // The mux is pure decode; no trigger is stored, so a late one is lost.
    // Trigger source select.
    always_comb begin
        unique case (q.trigSel)
            ASQ_TRG_HEAD_ONE: trigHit = timerTrig.headTimerCompareOne;
            ASQ_TRG_HEAD_TWO: trigHit = timerTrig.headTimerCompareTwo;
            ASQ_TRG_FRAME_THREE: trigHit = timerTrig.frameTimerCompareThree;
            ASQ_TRG_INTERVAL: trigHit = timerTrig.intervalTimerCompare;
        endcase
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************
    // The address is decoded straight off the bus, so data is ready when taken.
    // Read mux; unmapped addresses read zero with SLVERR.
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (s_axi_araddr)
            ASQ_OFS_MODE: rdMux = {24'h000000, q.mode};
            ASQ_OFS_RESULT: rdMux = {24'h000000, q.result};
            ASQ_OFS_TRIG: rdMux = {30'h0, q.trigSel};
            ASQ_OFS_IRQ_STATUS: rdMux = {31'h0, q.irqStatus};
            ASQ_OFS_IRQ_MASK: rdMux = {31'h0, q.irqMask};
            ASQ_OFS_STATE: rdMux = {22'h0, q.resultUnread, q.channel, 2'b00, q.state, 1'b0};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Handshake strobes
    // ****************************************************************
    // A write fires once both halves are held and no response is waiting.
    assign wrFire = q.haveAw && q.haveW && !q.bValid;
    assign rdFire = s_axi_arvalid && q.arReady;
    assign resultRead = rdFire && (s_axi_araddr == ASQ_OFS_RESULT);
    assign trial = q.sar | (8'h80 >> q.bitIdx);
    // Clamp the programmed input so the mux never leaves the twelve inputs.
    assign selCh = (q.mode.channel > ASQ_LAST_CH) ? ASQ_LAST_CH : q.mode.channel;
    // A mode write landing as a scan ends keeps the start bit it writes.
    assign modeWr = wrFire && q.wStrb[0] && (q.awAddr == ASQ_OFS_MODE);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_q = q;
        startReq = 1'b0;
        // The comparator is asynchronous and passes two flops before use.
        next_q.compSync1 = compHigh;
        next_q.compSync2 = q.compSync1;

        // Write address and data are taken independently, in either order.
        // awready and wready stay low while a half is held or a response waits.
        if (s_axi_awvalid && q.awReady) begin
            next_q.awAddr = s_axi_awaddr;
            next_q.haveAw = 1'b1;
        end
        if (s_axi_wvalid && q.wReady) begin
            next_q.wData = s_axi_wdata;
            next_q.wStrb = s_axi_wstrb;
            next_q.haveW = 1'b1;
        end
        next_q.awReady = !next_q.haveAw && !q.bValid;
        next_q.wReady = !next_q.haveW && !q.bValid;

        if (wrFire) begin
            next_q.haveAw = 1'b0;
            next_q.haveW = 1'b0;
            next_q.bValid = 1'b1;
            next_q.bResp = 2'b00;
            // Writes with the low byte lane off are answered but change nothing.
            if (q.wStrb[0]) begin
                unique case (q.awAddr)
                    ASQ_OFS_MODE: next_q.mode = asq_mode_t'(q.wData[7:0]);
                    ASQ_OFS_TRIG: next_q.trigSel = asq_trig_sel_t'(q.wData[1:0]);
                    ASQ_OFS_IRQ_STATUS: next_q.irqStatus = q.irqStatus & ~q.wData[0];
                    ASQ_OFS_IRQ_MASK: next_q.irqMask = q.wData[0];
                    ASQ_OFS_RESULT, ASQ_OFS_STATE: next_q.bResp = 2'b00;
                    default: next_q.bResp = 2'b10;
                endcase
            end
        end else if (q.bValid && s_axi_bready) begin
            next_q.bValid = 1'b0;
            next_q.awReady = !q.haveAw;
            next_q.wReady = !q.haveW;
        end

        // Read channel; data is registered, so the answer comes one cycle later.
        // Reads beyond the map or off a word boundary answer with a slave error.
        if (rdFire) begin
            next_q.arReady = 1'b0;
            next_q.rValid = 1'b1;
            next_q.rData = rdMux;
            next_q.rResp = (s_axi_araddr > ASQ_OFS_STATE || s_axi_araddr[1:0] != 2'b00)
                ? 2'b10 : 2'b00;
        end else if (q.rValid && s_axi_rready) begin
            next_q.rValid = 1'b0;
            next_q.arReady = 1'b1;
        end
        // Reading the result frees the hold-off.
        if (resultRead) begin
            next_q.resultUnread = 1'b0;
        end

        // Conversion sequencer.
        unique case (q.state)
            ASQ_IDLE: begin
                if (q.mode.hwStart && trigHit) begin
                    startReq = 1'b1;
                end
                // A start bit left set keeps a select-mode loop going.
                // Software start bit.
                if (!q.mode.hwStart && q.mode.start) begin
                    startReq = 1'b1;
                end
                if (startReq) begin
                    next_q.state = ASQ_SAMPLE;
                    // Channel from mode settings.
                    // Scan opens at the first input; select takes the clamped one.
                    next_q.channel = q.mode.scan ? 4'h0 : selCh;
                    next_q.cnt = SAMPLE_CNT;
                end
            end
            ASQ_SAMPLE: begin
                // The mux settles on the channel before the first trial code goes out.
                // Sample phase first.
                if (q.cnt == '0) begin
                    next_q.state = ASQ_CONVERT;
                    next_q.sar = 8'h00;
                    next_q.bitIdx = 3'h0;
                    next_q.cnt = STEP_CNT;
                end else begin
                    next_q.cnt = q.cnt - ASQ_CNT_W'(1);
                end
            end
            ASQ_CONVERT: begin
                // The synchronised comparator lags two cycles; each step outlasts it.
                // A kept bit stays set in the approximation register.
                // One bit per step, MSB first.
                if (q.cnt != '0) begin
                    next_q.cnt = q.cnt - ASQ_CNT_W'(1);
                end else begin
                    next_q.sar = q.compSync2 ? trial : q.sar;
                    next_q.cnt = STEP_CNT;
                    next_q.bitIdx = q.bitIdx + 3'h1;
                    if (q.bitIdx == 3'h7) begin
                        next_q.result = q.compSync2 ? trial : q.sar;
                        next_q.resultUnread = 1'b1;
                        next_q.irqStatus = 1'b1;
                        next_q.state = ASQ_HOLDOFF;
                    end
                end
            end
            ASQ_HOLDOFF: begin
                // Wait for the read in hold-off mode.
                if (!(q.mode.holdOff && q.resultUnread)) begin
                    // In hardware select mode each trigger buys one conversion.
                    // Triggers are not restarts here.
                    if (q.mode.hwStart && !q.mode.scan) begin
                        next_q.state = ASQ_IDLE;
                    end else if (!q.mode.start && !q.mode.hwStart) begin
                        next_q.state = ASQ_IDLE;
                    end else if (q.mode.scan) begin
                        if (q.channel == q.mode.channel || q.channel == ASQ_LAST_CH) begin
                            next_q.state = ASQ_IDLE;
                            // A software write in the same cycle wins over this clear.
                            if (!q.mode.hwStart && !modeWr) begin
                                next_q.mode.start = 1'b0;
                            end
                        end else begin
                            next_q.channel = q.channel + 4'h1;
                            next_q.state = ASQ_SAMPLE;
                            next_q.cnt = SAMPLE_CNT;
                        end
                    end else begin
                        next_q.channel = selCh;
                        next_q.state = ASQ_SAMPLE;
                        next_q.cnt = SAMPLE_CNT;
                    end
                end
            end
        endcase

        // A completion and a clear in one cycle: the set is written last and wins.
        // Masked level interrupt.
        next_q.irqOut = next_q.irqStatus && next_q.irqMask;

        // Analog strobes come from flops so the pins never glitch on decode.
        next_q.sampleOut = (next_q.state == ASQ_SAMPLE);
        next_q.dacOut = (next_q.state == ASQ_CONVERT)
            ? (next_q.sar | (8'h80 >> next_q.bitIdx)) : next_q.sar;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset parks the bus ready and the sequencer idle.
    // Reset is synchronous; it is sampled like any other input.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.awReady <= 1'b1;
            q.wReady <= 1'b1;
            q.arReady <= 1'b1;
            q.mode <= asq_mode_t'(ASQ_MODE_RESET);
            q.trigSel <= asq_trig_sel_t'(ASQ_TRIG_RESET);
            q.result <= ASQ_RESULT_RESET;
            q.state <= ASQ_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output comes from a flop of the state struct.
    // Outputs straight from the state register.
    assign s_axi_awready = q.awReady;
    assign s_axi_wready = q.wReady;
    assign s_axi_bresp = q.bResp;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_arready = q.arReady;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;
    assign s_axi_rvalid = q.rValid;
    assign muxChannel = q.channel;
    assign sampleHold = q.sampleOut;
    assign dacCode = q.dacOut;
    assign conversionDoneIrq = q.irqOut;

endmodule : asq_adc_sequencer

// ### sim/asq_adc_sequencer_properties.sv
module asq_adc_sequencer_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] muxChannel,
    input wire logic sampleHold,
    input wire logic [7:0] dacCode
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Port properties
    // ****************************************************************
    logic [7:0] gapCnt;
    logic holdDly;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Counts cycles since the sample strobe last rose, saturating at the top.
    always_ff @(posedge clk) begin
        holdDly <= sampleHold;
        if (!rst_b) begin
            gapCnt <= 8'hFF;
        end else if (sampleHold && !holdDly) begin
            gapCnt <= 8'h00;
        end else if (gapCnt != 8'hFF) begin
            gapCnt <= gapCnt + 8'h01;
        end
    end
    chk_chan_range: assert property (muxChannel <= 4'hB)
        else $error("mux channel beyond last input");
    chk_sample_width: assert property ($rose(sampleHold) |-> ##23 sampleHold ##1 !sampleHold)
        else $error("sample phase not 24 cycles");
    chk_first_trial: assert property ($fell(sampleHold) |-> dacCode == 8'h80)
        else $error("first trial code not midscale");
    chk_chan_steady: assert property (sampleHold && holdDly |-> $stable(muxChannel))
        else $error("channel moved during sampling");
    chk_no_restart: assert property (sampleHold && !holdDly |-> gapCnt >= 8'hC7)
        else $error("conversion restarted early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    cover property ($rose(sampleHold));
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : asq_adc_sequencer_properties

// ### sim/asq_analog_model.sv
module asq_analog_model (
    input wire logic [3:0] muxChannel,
    input wire logic [7:0] dacCode,
    output logic compHigh
);
    timeunit 1ns;
    timeprecision 100ps;
    // Mux picks level
    // Each input carries a distinct level: the channel number then 6.
    assign compHigh = ({muxChannel, 4'h6} >= dacCode);
endmodule : asq_analog_model

// ### sim/asq_adc_sequencer_tb_top.sv
`define ASQ_CHECK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
bind asq_adc_sequencer asq_adc_sequencer_properties chk (.clk(clk), .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .muxChannel(muxChannel),
    .sampleHold(sampleHold), .dacCode(dacCode));
module asq_adc_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import asq_pkg::*;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, compHigh, sampleHold, irq;
    logic awready, wready, bvalid, arready, rvalid, seen;
    logic [7:0] awaddr, araddr, dacCode;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] muxChannel;
    asq_trig_t timerTrig;
    int miscompares, checkCount;
    asq_adc_sequencer uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timerTrig(timerTrig), .muxChannel(muxChannel), .sampleHold(sampleHold),
        .dacCode(dacCode), .compHigh(compHigh), .conversionDoneIrq(irq));
    asq_analog_model ana (.muxChannel(muxChannel), .dacCode(dacCode), .compHigh(compHigh));
    // The clock toggles every half period of 25 ns.
    always #25 clk = ~clk;
    // Offers address and data together and holds each until it is taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
        logic pa, pw, pb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pb) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                pb = 1'b0;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask : axi_write
    // Holds the read address until taken and ready until the answer comes.
    task automatic axi_read(input logic [7:0] a);
        logic pa, pr;
        pa = 1'b1;
        pr = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pr) begin
            @(posedge clk);
            if (pa && arready) begin
                pa = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                pr = 1'b0;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask : axi_read
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        `ASQ_CHECK("register", e, d)
    endtask : rd_chk
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        `ASQ_CHECK("irq", 1'b1, irq)
    endtask : wait_irq
    // Notes whether the sample strobe is high at any edge within the given number of cycles.
    task automatic watch_hold(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (sampleHold === 1'b1) seen = 1'b1;
        end
    endtask : watch_hold
    task automatic pulse(input int s);
        timerTrig <= asq_trig_t'(4'h1 << s);
        @(posedge clk);
        timerTrig <= '0;
    endtask : pulse
    task automatic test_reset();
        rd_chk(ASQ_OFS_MODE, 32'h0);
        rd_chk(ASQ_OFS_RESULT, 32'h0);
        rd_chk(ASQ_OFS_TRIG, 32'h0);
        rd_chk(8'h20, 32'h0);
        `ASQ_CHECK("unmapped resp", 2'h2, r)
        axi_write(8'h20, 32'h0);
        `ASQ_CHECK("unmapped write resp", 2'h2, r)
    endtask : test_reset
    task automatic test_select();
        axi_write(ASQ_OFS_IRQ_MASK, 32'h1);
        axi_write(ASQ_OFS_MODE, 32'h51);
        `ASQ_CHECK("write resp", 2'h0, r)
        wait_irq();
        `ASQ_CHECK("channel", 4'h5, muxChannel)
        rd_chk(ASQ_OFS_RESULT, 32'h56);
        rd_chk(ASQ_OFS_IRQ_STATUS, 32'h1);
        axi_write(ASQ_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        `ASQ_CHECK("masked irq", 1'b0, irq)
        axi_write(ASQ_OFS_IRQ_MASK, 32'h1);
        axi_write(ASQ_OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        `ASQ_CHECK("cleared irq", 1'b0, irq)
        wait_irq();
        rd_chk(ASQ_OFS_RESULT, 32'h56);
        axi_write(ASQ_OFS_MODE, 32'h0);
        repeat (260) @(posedge clk);
        axi_write(ASQ_OFS_IRQ_STATUS, 32'h1);
    endtask : test_select
    task automatic test_scan();
        axi_write(ASQ_OFS_MODE, 32'h3D);
        for (int i = 0; i < 4; i++) begin
            wait_irq();
            watch_hold(300);
            `ASQ_CHECK("held off", 1'b0, seen)
            rd_chk(ASQ_OFS_RESULT, {24'h0, i[3:0], 4'h6});
            axi_write(ASQ_OFS_IRQ_STATUS, 32'h1);
        end
        watch_hold(300);
        `ASQ_CHECK("scan end", 1'b0, seen)
        rd_chk(ASQ_OFS_MODE, 32'h3C);
    endtask : test_scan
    task automatic test_hw();
        axi_write(ASQ_OFS_MODE, 32'h32);
        for (int s = 0; s < 4; s++) begin
            axi_write(ASQ_OFS_TRIG, s);
            pulse((s + 1) % 4);
            watch_hold(6);
            `ASQ_CHECK("other trigger", 1'b0, seen)
            pulse(s);
            watch_hold(6);
            `ASQ_CHECK("hw start", 1'b1, seen)
            pulse(s);
            wait_irq();
            rd_chk(ASQ_OFS_RESULT, 32'h36);
            axi_write(ASQ_OFS_IRQ_STATUS, 32'h1);
            watch_hold(240);
            `ASQ_CHECK("late trigger", 1'b0, seen)
        end
    endtask : test_hw
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    // Resets the block, then runs every scenario in turn.
    initial begin
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        timerTrig = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        test_reset();
        test_select();
        test_scan();
        test_hw();
        complete_run();
    end
endmodule : asq_adc_sequencer_tb_top
